// ==== include/cache_pkg.sv ====
// Purpose: Shared constants and carriers for the split logical caches.
// Assumes: 32-bit long words, one bus master port shared by both caches.
// Notes:   Cache control bits arrive as plain inputs; there is no register bus.
//
// What this block does
// RL1 - Separate instruction and data caches, both indexed and tagged by logical address.
// RL2 - Each cache holds 256 bytes as 16 entries.
// RL3 - Each entry is four consecutive long words under one tag.
// RL4 - Single transfers fill one long word, touching only that word.
// RL5 - Accepted bursts fill a whole entry with four consecutive long words.
// RL6 - Data write hits update the cache and always write memory too.
// RL7 - Data write misses allocate only when write allocation is enabled.
// RL8 - Lookups need no translated address, so translation never delays them.
// RL9 - Read hits start no bus cycle; read misses fetch and fill the missed word, or the whole entry when a burst is accepted.
package cache_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int CACHE_BYTES = 256;
	localparam int ENTRIES     = 16;
	localparam int WORDS       = 4;
	localparam int LINE_BYTES  = CACHE_BYTES / ENTRIES;
	localparam int WORD_LSB    = 2;
	localparam int INDEX_LSB   = 4;
	localparam int TAG_LSB     = 8;
	localparam int TAG_W       = 32 - TAG_LSB;
	localparam int CACHE_I     = 0;
	localparam int CACHE_D     = 1;
	localparam logic [1:0] LAST_BEAT = 2'h3;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        cacheable;
		logic [31:0] laddr;
		logic [31:0] paddr;
		logic [31:0] wdata;
	} core_req_type;

	typedef struct packed {
		logic i_enable;
		logic d_enable;
		logic i_burst;
		logic d_burst;
		logic write_alloc;
		logic i_clear;
		logic d_clear;
	} cache_control_register_type;

	typedef struct packed {
		logic        req;
		logic        we;
		logic        burst;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bus_req_type;

endpackage : cache_pkg

// ==== rtl/onchip_logical_caches.sv ====
// Purpose: Instruction and data logical caches sharing one external bus port.
// Assumes: Requesters hold valid until ack and drop it at the edge that samples ack.
// Notes:   Long-word accesses only; write-through with optional write allocation.
`timescale 1ns/1ps
module onchip_logical_caches (
	input  wire logic                                 CLK_I,          // 40 MHz clock
	input  wire logic                                 ARST_N_I,       // Async reset, low
	input  wire cache_pkg::cache_control_register_type CTRL_I,        // Cache control bits
	input  wire cache_pkg::core_req_type              I_REQ_I,        // Instruction fetch
	output logic                                      I_ACK_O,        // Fetch done pulse
	output logic [31:0]                               I_RDATA_O,      // Fetched word
	input  wire cache_pkg::core_req_type              D_REQ_I,        // Data access
	output logic                                      D_ACK_O,        // Data done pulse
	output logic [31:0]                               D_RDATA_O,      // Read word
	output cache_pkg::bus_req_type                    BUS_O,          // External request
	input  wire logic                                 BUS_ACK_I,      // Beat done
	input  wire logic                                 BUS_BURST_ACK_I, // Burst accepted
	input  wire logic [31:0]                          BUS_RDATA_I     // Beat read data
);

	typedef enum logic [0:0] {ST_IDLE, ST_BUS} state_type;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [cache_pkg::TAG_W-1:0] tag_ff   [2][cache_pkg::ENTRIES]; // RL2
	logic [cache_pkg::WORDS-1:0] valid_ff [2][cache_pkg::ENTRIES]; // RL2
	logic [31:0]                 data_ff  [2][cache_pkg::ENTRIES][cache_pkg::WORDS]; // RL2 RL3

	state_type   state_ff;
	logic        sel_ff;
	logic        we_ff;
	logic        fill_ff;
	logic        burst_ff;
	logic [3:0]  idx_ff;
	logic [1:0]  word_ff;
	logic [1:0]  cnt_ff;
	logic [31:0] first_ff;
	logic        i_ack_ff;
	logic        d_ack_ff;
	logic [31:0] i_rdata_ff;
	logic [31:0] d_rdata_ff;
	cache_pkg::bus_req_type bus_ff;

	// ----------------------------------------------------------------
	// Lookup on the logical address only
	// ----------------------------------------------------------------
	logic                        pick_i;
	logic                        pick_d;
	logic                        go;
	logic                        sel;
	cache_pkg::core_req_type     cur;
	logic                        en;
	logic [3:0]                  idx;
	logic [1:0]                  wsel;
	logic [cache_pkg::TAG_W-1:0] tag;
	logic                        tag_match;
	logic                        hit;
	logic                        newtag;
	logic                        idle_wr;
	logic                        fill_wr;
	logic                        beat_last;

	assign pick_i    = I_REQ_I.valid & ~i_ack_ff;
	assign pick_d    = D_REQ_I.valid & ~d_ack_ff;
	assign go        = (state_ff == ST_IDLE) & (pick_i | pick_d);
	assign sel       = ~pick_i;
	assign cur       = sel ? D_REQ_I : I_REQ_I;
	assign en        = cur.cacheable & (sel ? CTRL_I.d_enable : CTRL_I.i_enable);
	// Index, word and tag all come from laddr, so paddr may settle late
	assign idx       = cur.laddr[cache_pkg::TAG_LSB-1:cache_pkg::INDEX_LSB]; // RL8 RL1
	assign wsel      = cur.laddr[cache_pkg::INDEX_LSB-1:cache_pkg::WORD_LSB]; // RL3
	assign tag       = cur.laddr[31:cache_pkg::TAG_LSB]; // RL1
	assign tag_match = en & (tag_ff[sel][idx] == tag);
	assign hit       = tag_match & valid_ff[sel][idx][wsel];
	// Instruction side is read only, so a write can only come from the data port
	assign idle_wr   = go & cur.write & sel & en & (tag_match | CTRL_I.write_alloc); // RL6 RL7
	assign newtag    = go & en & ~tag_match & (~cur.write | (sel & CTRL_I.write_alloc)); // RL7 RL9
	assign fill_wr   = (state_ff == ST_BUS) & BUS_ACK_I & ~we_ff & fill_ff; // RL4 RL9
	assign beat_last = (cnt_ff == 2'h0) ? ~(burst_ff & BUS_BURST_ACK_I) : (cnt_ff == cache_pkg::LAST_BEAT); // RL5

	// ----------------------------------------------------------------
	// Tags and valid bits
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			for (int c = 0; c < 2; c++) begin
				for (int e = 0; e < cache_pkg::ENTRIES; e++) begin
					valid_ff[c][e] <= '0;
					tag_ff[c][e]   <= '0;
				end
			end
		end else begin
			for (int e = 0; e < cache_pkg::ENTRIES; e++) begin
				if (CTRL_I.i_clear) begin
					valid_ff[cache_pkg::CACHE_I][e] <= '0;
				end
				if (CTRL_I.d_clear) begin
					valid_ff[cache_pkg::CACHE_D][e] <= '0;
				end
			end
			// Line is dropped as soon as it is reallocated, so a stale word never hits
			if (newtag) begin
				tag_ff[sel][idx]   <= tag;
				valid_ff[sel][idx] <= '0;
			end
			if (idle_wr) begin
				valid_ff[sel][idx][wsel] <= 1'b1; // RL6
			end
			if (fill_wr) begin
				valid_ff[sel_ff][idx_ff][word_ff] <= 1'b1; // RL4
			end
		end
	end

	// Data words carry no reset; valid bits guard them
	always_ff @(posedge CLK_I) begin
		if (idle_wr) begin
			data_ff[sel][idx][wsel] <= cur.wdata; // RL6
		end
		if (fill_wr) begin
			data_ff[sel_ff][idx_ff][word_ff] <= BUS_RDATA_I; // RL4 RL5
		end
	end

	// ----------------------------------------------------------------
	// Control sequence
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_ff <= ST_IDLE;
			sel_ff   <= 1'b0;
			we_ff    <= 1'b0;
			fill_ff  <= 1'b0;
			burst_ff <= 1'b0;
			idx_ff   <= '0;
			word_ff  <= '0;
			cnt_ff   <= '0;
			first_ff <= '0;
			bus_ff   <= '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (go && (cur.write || !hit)) begin // RL9
						state_ff     <= ST_BUS;
						sel_ff       <= sel;
						we_ff        <= cur.write;
						fill_ff      <= en & ~cur.write;
						burst_ff     <= en & ~cur.write & (sel ? CTRL_I.d_burst : CTRL_I.i_burst);
						idx_ff       <= idx;
						word_ff      <= wsel;
						cnt_ff       <= '0;
						bus_ff.req   <= 1'b1;
						bus_ff.we    <= cur.write; // RL6
						bus_ff.burst <= en & ~cur.write & (sel ? CTRL_I.d_burst : CTRL_I.i_burst); // RL5
						bus_ff.addr  <= cur.paddr;
						bus_ff.wdata <= cur.wdata;
					end
				end
				ST_BUS: begin
					if (BUS_ACK_I) begin
						if (cnt_ff == 2'h0) begin
							first_ff <= BUS_RDATA_I;
						end
						if (we_ff || beat_last) begin
							state_ff     <= ST_IDLE;
							bus_ff.req   <= 1'b0;
							bus_ff.burst <= 1'b0;
						end else begin
							// Burst wraps inside the line from the requested word
							cnt_ff                 <= cnt_ff + 2'h1; // RL5
							word_ff                <= word_ff + 2'h1;
							bus_ff.addr[3:2]       <= bus_ff.addr[3:2] + 2'h1;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Answers to the core
	// ----------------------------------------------------------------
	logic        done;
	logic [31:0] done_data;

	assign done      = (state_ff == ST_BUS) & BUS_ACK_I & (we_ff | beat_last);
	assign done_data = (cnt_ff == 2'h0) ? BUS_RDATA_I : first_ff;

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			i_ack_ff   <= 1'b0;
			d_ack_ff   <= 1'b0;
			i_rdata_ff <= '0;
			d_rdata_ff <= '0;
		end else begin
			i_ack_ff <= (go & hit & ~cur.write & ~sel) | (done & ~sel_ff); // RL9
			d_ack_ff <= (go & hit & ~cur.write & sel) | (done & sel_ff);
			if (go && hit && !cur.write) begin
				if (sel) begin
					d_rdata_ff <= data_ff[sel][idx][wsel];
				end else begin
					i_rdata_ff <= data_ff[sel][idx][wsel];
				end
			end else if (done && !we_ff) begin
				if (sel_ff) begin
					d_rdata_ff <= done_data;
				end else begin
					i_rdata_ff <= done_data;
				end
			end
		end
	end

	assign I_ACK_O   = i_ack_ff;
	assign I_RDATA_O = i_rdata_ff;
	assign D_ACK_O   = d_ack_ff;
	assign D_RDATA_O = d_rdata_ff;
	assign BUS_O     = bus_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_hit_no_bus: assert property ( // RL9
		@(posedge CLK_I) disable iff (!ARST_N_I)
		(go && hit && !cur.write) |=> ((I_ACK_O || D_ACK_O) && !BUS_O.req)
	) else $error("read hit did not answer from cache alone");

	a_miss_fetch: assert property ( // RL9
		@(posedge CLK_I) disable iff (!ARST_N_I)
		(go && !hit && !cur.write) |=> (BUS_O.req && !BUS_O.we)
	) else $error("read miss did not start a bus read");

	a_write_through: assert property ( // RL6
		@(posedge CLK_I) disable iff (!ARST_N_I)
		(go && cur.write) |=> (BUS_O.req && BUS_O.we && BUS_O.wdata == $past(cur.wdata))
	) else $error("data write did not reach memory");

	a_no_alloc: assert property ( // RL7
		@(posedge CLK_I) disable iff (!ARST_N_I)
		(go && cur.write && !tag_match && !CTRL_I.write_alloc) |=> (tag_ff[$past(sel)][$past(idx)] != $past(tag))
	) else $error("write miss allocated with allocation off");

	a_icache_ro: assert property ( // RL1
		@(posedge CLK_I) disable iff (!ARST_N_I)
		(go && sel && cur.write) |=> (tag_ff[cache_pkg::CACHE_I][$past(idx)] == $past(tag_ff[cache_pkg::CACHE_I][idx])
			&& (valid_ff[cache_pkg::CACHE_I][$past(idx)] == $past(valid_ff[cache_pkg::CACHE_I][idx])
			|| $past(CTRL_I.i_clear)))
	) else $error("instruction cache touched by a store");

	a_single_beat: assert property ( // RL4
		@(posedge CLK_I) disable iff (!ARST_N_I)
		(fill_wr && cnt_ff == 2'h0 && !(burst_ff && BUS_BURST_ACK_I)) |=> (state_ff == ST_IDLE)
	) else $error("single transfer filled more than one word");

	a_burst_len: assert property ( // RL5
		@(posedge CLK_I) disable iff (!ARST_N_I)
		(state_ff == ST_BUS && BUS_ACK_I && cnt_ff == cache_pkg::LAST_BEAT) |=> (state_ff == ST_IDLE && !BUS_O.req)
	) else $error("burst ran past four long words");

	a_fill_valid: assert property ( // RL5
		@(posedge CLK_I) disable iff (!ARST_N_I)
		fill_wr |=> valid_ff[$past(sel_ff)][$past(idx_ff)][$past(word_ff)]
	) else $error("filled word not marked valid");

	a_one_cycle: assert property ( // RL8
		@(posedge CLK_I) disable iff (!ARST_N_I)
		(go && hit && !cur.write && !sel) |=> (I_ACK_O && I_RDATA_O == $past(data_ff[sel][idx][wsel]))
	) else $error("hit answer late or wrong");

endmodule : onchip_logical_caches

// ==== tb/mem_model.sv ====
// Purpose: External memory partner serving line fills and write-through.
// Assumes: One transfer at a time; read data is taken with each beat ack.
// Notes:   slow_i sets wait cycles per beat; a released data line inverts.
`timescale 1ns/1ps
module mem_model (
	input  wire logic                   clk_i,       // Clock
	input  wire logic                   arst_n_i,    // Async reset, low
	input  wire cache_pkg::bus_req_type bus_i,       // Cache request
	input  wire logic                   burst_en_i,  // Burst capable
	input  wire logic [3:0]             slow_i,      // Wait per beat
	output logic                        ack_o,       // Beat done
	output logic                        burst_ack_o, // Burst accepted
	output logic [31:0]                 rdata_o,     // Beat data
	output logic [7:0]                  beats_o      // Beats served
);
	logic [31:0] mem_ff [64];
	logic [3:0]  wait_ff;
	logic        first_ff;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_o <= 1'b0;
			burst_ack_o <= 1'b0;
			rdata_o <= 32'h0;
			beats_o <= 8'h0;
			wait_ff <= 4'h0;
			first_ff <= 1'b1;
			for (int i = 0; i < 64; i++) begin
				mem_ff[i] <= 32'hc0de0000 + i;
			end
		end else begin
			ack_o <= 1'b0;
			burst_ack_o <= 1'b0;
			// Data line inverts every cycle after the beat, so the beat word only comes back on alternate cycles
			rdata_o <= ~rdata_o;
			if (!bus_i.req) begin
				wait_ff <= 4'h0;
				first_ff <= 1'b1;
			end else if (!ack_o) begin
				if (wait_ff < slow_i) begin
					wait_ff <= wait_ff + 4'h1;
				end else begin
					wait_ff <= 4'h0;
					ack_o <= 1'b1;
					first_ff <= 1'b0;
					beats_o <= beats_o + 8'h01;
					burst_ack_o <= first_ff & bus_i.burst & burst_en_i;
					rdata_o <= mem_ff[bus_i.addr[7:2]];
					if (bus_i.we) begin
						mem_ff[bus_i.addr[7:2]] <= bus_i.wdata;
					end
				end
			end
		end
	end
endmodule : mem_model

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the split logical caches.
// Assumes: Memory word at index n of bits 7:2 starts as c0de0000 plus n.
// Notes:   Bus beats are counted in the partner to tell hits from misses.
`timescale 1ns/1ps
module tb;
	logic                                  clk      = 1'b0;
	logic                                  arst_n   = 1'b0;
	logic                                  burst_en = 1'b0;
	logic [3:0]                            slow     = 4'h0;
	cache_pkg::cache_control_register_type ctrl     = '0;
	cache_pkg::core_req_type               ireq     = '0;
	cache_pkg::core_req_type               dreq     = '0;
	cache_pkg::bus_req_type                bus;
	logic                                  i_ack, d_ack, b_ack, b_burst;
	logic [31:0]                           i_rdata, d_rdata, b_rdata, got;
	logic [7:0]                            beats, b0;
	int                                    err_total = 0;
	int                                    checks    = 0;

	always #12.5 clk = ~clk;

	onchip_logical_caches dut_u (.CLK_I(clk), .ARST_N_I(arst_n), .CTRL_I(ctrl), .I_REQ_I(ireq),
		.I_ACK_O(i_ack), .I_RDATA_O(i_rdata), .D_REQ_I(dreq), .D_ACK_O(d_ack), .D_RDATA_O(d_rdata),
		.BUS_O(bus), .BUS_ACK_I(b_ack), .BUS_BURST_ACK_I(b_burst), .BUS_RDATA_I(b_rdata));
	mem_model mem_u (.clk_i(clk), .arst_n_i(arst_n), .bus_i(bus), .burst_en_i(burst_en), .slow_i(slow),
		.ack_o(b_ack), .burst_ack_o(b_burst), .rdata_o(b_rdata), .beats_o(beats));

	function automatic logic [31:0] pat(input logic [31:0] a);
		return {24'hc0de00, 2'b00, a[7:2]};
	endfunction : pat

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask : check

	task automatic access(input logic ds, input logic wr, input logic [31:0] la, input logic [31:0] pa,
		input logic [31:0] wd);
		cache_pkg::core_req_type r;
		int n;
		r = '{valid: 1'b1, write: wr, cacheable: 1'b1, laddr: la, paddr: pa, wdata: wd};
		@(posedge clk);
		#1;
		b0 = beats;
		if (ds) dreq = r;
		else ireq = r;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			#1;
			if ((ds ? d_ack : i_ack) === 1'b1) break;
		end
		check(n, n < 200 ? n : 0);
		got = ds ? d_rdata : i_rdata;
		@(posedge clk);
		#1;
		dreq.valid = 1'b0;
		ireq.valid = 1'b0;
	endtask : access

	// Read and compare word and number of bus beats spent
	task automatic rd(input logic ds, input logic [31:0] la, input logic [31:0] pa, input logic [31:0] e,
		input logic [7:0] nb);
		access(ds, 1'b0, la, pa, 32'h0);
		check(got, e);
		check({24'h0, beats - b0}, {24'h0, nb});
	endtask : rd

	task automatic t_single();
		slow = 4'h2;
		rd(0, 32'h100, 32'h100, pat(32'h100), 1);
		rd(0, 32'h104, 32'h104, pat(32'h104), 1);
		rd(0, 32'h100, 32'h100, pat(32'h100), 0);
	endtask : t_single

	task automatic t_burst();
		slow = 4'h0;
		ctrl.d_burst = 1'b1;
		burst_en = 1'b1;
		rd(1, 32'h208, 32'h208, pat(32'h208), 4);
		for (int w = 0; w < 4; w++) rd(1, 32'h200 + 4 * w, 32'h200 + 4 * w, pat(32'h200 + 4 * w), 0);
		access(1, 1'b1, 32'h204, 32'h204, 32'h12345678);
		check({24'h0, beats - b0}, 32'h1);
		rd(1, 32'h204, 32'h204, 32'h12345678, 0);
		rd(0, 32'h204, 32'h204, 32'h12345678, 1);
	endtask : t_burst

	task automatic t_alloc();
		ctrl.d_burst = 1'b0;
		access(1, 1'b1, 32'h304, 32'h304, 32'ha5a5a5a5);
		rd(1, 32'h304, 32'h304, 32'ha5a5a5a5, 1);
		ctrl.write_alloc = 1'b1;
		access(1, 1'b1, 32'h408, 32'h408, 32'h5a5a0f0f);
		rd(1, 32'h408, 32'h408, 32'h5a5a0f0f, 0);
		rd(1, 32'h500, 32'h500, pat(32'h500), 1);
		rd(1, 32'h500, 32'h53c, pat(32'h500), 0);
	endtask : t_alloc

	task automatic t_capacity();
		ctrl.d_burst = 1'b1;
		for (int i = 0; i < 16; i++) rd(1, 32'h1000 + 16 * i, 32'h1000 + 16 * i, pat(16 * i), 4);
		for (int i = 0; i < 16; i++) rd(1, 32'h1000 + 16 * i, 32'h1000 + 16 * i, pat(16 * i), 0);
		rd(1, 32'h2000, 32'h2000, pat(32'h0), 4);
		rd(1, 32'h1010, 32'h1010, pat(32'h10), 0);
	endtask : t_capacity

	// Instruction bursts, whole-cache clears and a disabled data cache
	task automatic t_modes();
		ctrl.i_burst = 1'b1;
		rd(0, 32'h100, 32'h100, pat(32'h100), 4);
		rd(0, 32'h10c, 32'h10c, pat(32'h10c), 0);
		ctrl.i_clear = 1'b1;
		ctrl.d_clear = 1'b1;
		@(posedge clk);
		#1;
		ctrl.i_clear = 1'b0;
		ctrl.d_clear = 1'b0;
		rd(0, 32'h10c, 32'h10c, pat(32'h10c), 4);
		rd(1, 32'h1010, 32'h1010, pat(32'h10), 4);
		ctrl.d_enable = 1'b0;
		rd(1, 32'h1010, 32'h1010, pat(32'h10), 1);
		rd(1, 32'h1010, 32'h1010, pat(32'h10), 1);
	endtask : t_modes

	task automatic summarize();
		if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	initial begin
		repeat (8) @(posedge clk);
		#1;
		arst_n = 1'b1;
		ctrl.i_enable = 1'b1;
		ctrl.d_enable = 1'b1;
		t_single();
		t_burst();
		t_alloc();
		t_capacity();
		t_modes();
		summarize();
	end

	// Whole run needs about four hundred cycles
	initial begin
		#(25 * 20000);
		err_total++;
		summarize();
	end
endmodule : tb
